//--- hdl/phy_irq_pkg.sv
// Register map, field layout and timing constants of the PHY status block
`default_nettype none
package phy_irq_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [5:0]  IDX_RX_POLARITY     = 6'h1b;
	localparam logic [5:0]  IDX_EVENT_CLEAR     = 6'h1c;
	localparam logic [5:0]  IDX_EVENT_STATUS    = 6'h1d;
	localparam logic [5:0]  IDX_EVENT_ENABLE    = 6'h1e;
	localparam logic [5:0]  IDX_SPECIAL         = 6'h1f;

	// Polarity register
	localparam int          POL_REVERSED_BIT    = 4;

	// Event status, enable and clear registers share this layout
	localparam int          EV_LO               = 1;
	localparam int          EV_HI               = 7;
	localparam int          EV_ENERGY           = 7;
	localparam int          EV_NEG_COMPLETE     = 6;
	localparam int          EV_REMOTE_FAULT     = 5;
	localparam int          EV_LINK_DOWN        = 4;
	localparam int          EV_PARTNER_ACK      = 3;
	localparam int          EV_PARALLEL_FAULT   = 2;
	localparam int          EV_PAGE_RECEIVED    = 1;
	localparam logic [15:0] EVENT_STATUS_RESET  = 16'h0000;
	localparam logic [15:0] EVENT_ENABLE_RESET  = 16'h0000;

	// Special control and status register
	localparam int          SP_RSVD_HI          = 15;
	localparam int          SP_RSVD_LO          = 13;
	localparam int          SP_NEG_DONE_BIT     = 12;
	localparam int          SP_MODE_HI          = 4;
	localparam int          SP_MODE_LO          = 2;
	localparam int          SP_RSVD1_BIT        = 1;
	localparam int          SP_SCR_DIS_BIT      = 0;
	localparam logic [15:0] SPECIAL_RESET       = 16'h0040;
	localparam logic [15:0] SPECIAL_WR_MASK     = 16'he003;

	// Resolved link mode codes
	localparam logic [2:0]  MODE_10_HALF        = 3'h1;
	localparam logic [2:0]  MODE_100_HALF       = 3'h2;
	localparam logic [2:0]  MODE_10_FULL        = 3'h5;
	localparam logic [2:0]  MODE_100_FULL       = 3'h6;

	// Line energy timeout
	localparam int          CLK_FREQ_HZ         = 100_000_000;
	localparam int          ENERGY_TIMEOUT_MS   = 256;
	localparam int          ENERGY_TIMEOUT_CYC  = ENERGY_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

	// Synchronised pin vector layout
	localparam int          PIN_POLARITY        = 0;
	localparam int          PIN_ENERGY          = 1;
	localparam int          PIN_NEG_DONE        = 2;
	localparam int          PIN_REMOTE_FAULT    = 3;
	localparam int          PIN_LINK_UP         = 4;
	localparam int          PIN_PARTNER_ACK     = 5;
	localparam int          PIN_PARALLEL_FAULT  = 6;
	localparam int          PIN_PAGE_RECEIVED   = 7;
	localparam int          PIN_MODE_LO         = 8;
	localparam int          PIN_MODE_HI         = 10;
	localparam int          PIN_COUNT           = 11;

endpackage
`default_nettype wire

//--- hdl/event_flags_if.sv
// Set, clear and flag vectors between the register file and the event latch
`default_nettype none
interface event_flags_if;
	import phy_irq_pkg::*;

	logic [EV_HI:EV_LO] set;
	logic [EV_HI:EV_LO] clear;
	logic [EV_HI:EV_LO] flag;

	modport latch (input set, input clear, output flag);
	modport regs  (output set, output clear, input flag);
endinterface
`default_nettype wire

//--- hdl/event_latch.sv
// Sticky event flags, one per source
`default_nettype none
module event_latch
	import phy_irq_pkg::*;
(
	// System
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// Event vectors
	event_flags_if.latch       ev
);

	genvar i;
	generate
		for (i = EV_LO; i <= EV_HI; i++) begin : g_flag
			// A new event in the clearing cycle survives the clear
			always_ff @(posedge clk_i) begin
				if (rst_i)
					ev.flag[i] <= EVENT_STATUS_RESET[i];
				else if (ev.set[i])
					ev.flag[i] <= 1'b1;
				else if (ev.clear[i])
					ev.flag[i] <= 1'b0;
			end
		end
	endgenerate

endmodule
`default_nettype wire

//--- hdl/energy_monitor.sv
// Line energy indication with no-energy timeout
`default_nettype none
module energy_monitor
	import phy_irq_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYC
)
(
	// System
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Energy
	input  wire logic energy_present_i,
	output var  logic line_energy_indication_o
);

	localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);

	// A zero timeout would leave the counter with nothing to count
	if (TIMEOUT_CYCLES < 1) begin : g_timeout_check
		$error("TIMEOUT_CYCLES must be at least one");
	end

	logic [CNT_W-1:0] quiet_count;
	wire  logic       expired = (quiet_count == CNT_W'(TIMEOUT_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i)
			quiet_count <= '0;
		else if (energy_present_i || expired)
			quiet_count <= '0;
		else
			quiet_count <= quiet_count + CNT_W'(1);
	end

	// Set by reset, so a quiet line reads as energised until the timeout runs out
	always_ff @(posedge clk_i) begin
		if (rst_i)
			line_energy_indication_o <= 1'b1;
		else if (energy_present_i)
			line_energy_indication_o <= 1'b1;
		else if (expired)
			line_energy_indication_o <= 1'b0;
	end

endmodule
`default_nettype wire

//--- hdl/phy_interrupt_status_control.sv
// PHY polarity, event, interrupt and special control registers on classic Wishbone
`default_nettype none

// Function
// - Status bit 4 shows receive pair reversed polarity.
// - Event bit 7 latches a change of line energy indication.
// - Event bit 6 latches completion of auto-negotiation.
// - Event bit 5 latches detection of a remote fault.
// - Event bit 4 latches the link status going down.
// - Event bit 3 latches an acknowledge from the partner.
// - Event bit 2 latches a parallel detection fault.
// - Event bit 1 latches a received negotiation page.
// - Enable bits 7..1 gate each event source onto the interrupt.
// - Special register bit 12 shows negotiation done.
// - Special bits 4:2 report resolved speed and duplex code.
// - Special bit 0 disables scrambling while set.
// - Energy indication clears after 256 ms quiet, sets at reset.
module phy_interrupt_status_control
	import phy_irq_pkg::*;
#(
	parameter int ADDR_W         = 8,
	parameter int TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYC
)
(
	// System
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output var  logic [31:0]       dat_o,
	output var  logic              ack_o,
	// Physical layer indications
	input  wire logic              rx_polarity_reversed_i,
	input  wire logic              line_energy_present_i,
	input  wire logic              negotiation_done_i,
	input  wire logic              remote_fault_i,
	input  wire logic              link_status_i,
	input  wire logic              partner_ack_i,
	input  wire logic              parallel_detect_fault_i,
	input  wire logic              page_received_i,
	input  wire logic [2:0]        link_mode_i,
	// Control and interrupt
	output var  logic              scrambler_disable_o,
	output var  logic              line_energy_indication_o,
	output var  logic              irq_o
);

	// Elaboration checks; the decode needs the full register index in adr_i[7:2]
	if (ADDR_W < 8) begin : g_addr_check
		$error("ADDR_W must be at least 8");
	end
	if (TIMEOUT_CYCLES < 1) begin : g_timeout_check
		$error("TIMEOUT_CYCLES must be at least one");
	end

	// Pin synchronisers; stage one feeds only stage two
	wire  logic [PIN_COUNT-1:0] pins_raw = {
		link_mode_i,
		page_received_i,
		parallel_detect_fault_i,
		partner_ack_i,
		link_status_i,
		remote_fault_i,
		negotiation_done_i,
		line_energy_present_i,
		rx_polarity_reversed_i
	};
	logic [PIN_COUNT-1:0]       pins_meta;
	logic [PIN_COUNT-1:0]       pins;
	logic [PIN_COUNT-1:0]       pins_prev;

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pins_meta[p] <= 1'b0;
					pins[p]      <= 1'b0;
				end else begin
					pins_meta[p] <= pins_raw[p];
					pins[p]      <= pins_meta[p];
				end
			end
		end
	endgenerate

	// Previous values start equal to the idle levels so reset makes no edge
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pins_prev <= '0;
		else
			pins_prev <= pins;
	end

	wire logic [PIN_COUNT-1:0] pins_rise = pins & ~pins_prev;
	wire logic [PIN_COUNT-1:0] pins_fall = ~pins & pins_prev;

	// Line energy indication
	logic energy_ind;
	logic energy_ind_prev;

	energy_monitor #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_energy (
		.clk_i                    (clk_i),
		.rst_i                    (rst_i),
		.energy_present_i         (pins[PIN_ENERGY]),
		.line_energy_indication_o (energy_ind)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			energy_ind_prev <= 1'b1;
		else
			energy_ind_prev <= energy_ind;
	end

	// Both directions count as a change of the indication
	wire logic energy_changed = energy_ind ^ energy_ind_prev;

	// Event sources and sticky flags
	event_flags_if ev ();

	assign ev.set[EV_ENERGY]         = energy_changed;
	assign ev.set[EV_NEG_COMPLETE]   = pins_rise[PIN_NEG_DONE];
	assign ev.set[EV_REMOTE_FAULT]   = pins_rise[PIN_REMOTE_FAULT];
	assign ev.set[EV_LINK_DOWN]      = pins_fall[PIN_LINK_UP];
	assign ev.set[EV_PARTNER_ACK]    = pins_rise[PIN_PARTNER_ACK];
	assign ev.set[EV_PARALLEL_FAULT] = pins_rise[PIN_PARALLEL_FAULT];
	assign ev.set[EV_PAGE_RECEIVED]  = pins_rise[PIN_PAGE_RECEIVED];

	event_latch u_latch (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ev    (ev.latch)
	);

	// Wishbone decode; one access per request, taken in the cycle before ack
	wire logic       access  = cyc_i & stb_i & ~ack_o;
	wire logic [5:0] index   = adr_i[7:2];
	wire logic       upper_ok = (ADDR_W == 8) ? 1'b1 : ~|(adr_i >> 8);
	wire logic       hit_pol  = upper_ok & (index == IDX_RX_POLARITY);
	wire logic       hit_clr  = upper_ok & (index == IDX_EVENT_CLEAR);
	wire logic       hit_sts  = upper_ok & (index == IDX_EVENT_STATUS);
	wire logic       hit_ena  = upper_ok & (index == IDX_EVENT_ENABLE);
	wire logic       hit_spc  = upper_ok & (index == IDX_SPECIAL);
	wire logic       wr      = access & we_i;
	wire logic       wr_ena  = wr & hit_ena;
	wire logic       wr_clr  = wr & hit_clr;
	wire logic       wr_spc  = wr & hit_spc;
	wire logic       rd_req  = access & ~we_i;
	wire logic [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

	// Enable register
	logic [15:0] event_enable;
	wire  logic [15:0] ena_bits = 16'((1 << (EV_HI + 1)) - (1 << EV_LO));
	wire  logic [15:0] ena_wmask = lane_mask & ena_bits;
	wire  logic [15:0] next_enable = (event_enable & ~ena_wmask) | (dat_i[15:0] & ena_wmask);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			event_enable <= EVENT_ENABLE_RESET;
		else if (wr_ena)
			event_enable <= next_enable;
	end

	// Writing ones to the clear register drops those flags
	assign ev.clear = wr_clr ? (dat_i[EV_HI:EV_LO] & lane_mask[EV_HI:EV_LO])
		: '0;

	// Special control: reserved writable bits are stored as written
	logic [15:0] special_ctrl;
	wire  logic [15:0] spc_wmask = lane_mask & SPECIAL_WR_MASK;
	wire  logic [15:0] next_special = (special_ctrl & ~spc_wmask) | (dat_i[15:0] & spc_wmask);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			special_ctrl <= SPECIAL_RESET & SPECIAL_WR_MASK;
		else if (wr_spc)
			special_ctrl <= next_special;
	end

	// The mode code crosses as three separate bits; only a code that stood
	// still for two samples is shown, so a read never sees a mixed code
	wire  logic [2:0] mode_sync   = pins[PIN_MODE_HI:PIN_MODE_LO];
	wire  logic [2:0] mode_last   = pins_prev[PIN_MODE_HI:PIN_MODE_LO];
	wire  logic       mode_steady = (mode_sync == mode_last);
	logic [2:0]       mode_held;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			mode_held <= 3'h0;
		else if (mode_steady)
			mode_held <= mode_sync;
	end

	// Read views
	wire logic [15:0] pol_view = 16'(pins[PIN_POLARITY]) << POL_REVERSED_BIT;
	wire logic [15:0] sts_view = {8'h00, ev.flag, 1'b0};
	wire logic [15:0] ena_view = event_enable;
	wire logic [15:0] spc_view = (special_ctrl & SPECIAL_WR_MASK)
		| (16'(pins[PIN_NEG_DONE]) << SP_NEG_DONE_BIT)
		| (16'(mode_held) << SP_MODE_LO);

	wire logic [15:0] read_word = hit_pol ? pol_view
		: hit_sts ? sts_view
		: hit_ena ? ena_view
		: hit_spc ? spc_view
		: 16'h0000;

	// Ack one cycle after the request; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= access;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (rd_req)
			dat_o <= {16'h0000, read_word};
	end

	// Interrupt and control outputs
	wire logic [EV_HI:EV_LO] pending  = ev.flag & event_enable[EV_HI:EV_LO];
	wire logic               irq_next = |pending;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= irq_next;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			scrambler_disable_o <= 1'b0;
		else
			scrambler_disable_o <= special_ctrl[SP_SCR_DIS_BIT];
	end

	// One cycle behind the monitor; reset sets it just as the monitor does
	always_ff @(posedge clk_i) begin
		if (rst_i)
			line_energy_indication_o <= 1'b1;
		else
			line_energy_indication_o <= energy_ind;
	end

endmodule
`default_nettype wire

//--- testbench/phy_link_partner.sv
// Behavioural link partner driving the PHY indication pins
`default_nettype none
module phy_link_partner (
	// System
	input  wire logic       clk_i,
	// Indications
	output var  logic       pol_o,
	output var  logic       energy_o,
	output var  logic [7:1] ev_o,
	output var  logic [2:0] mode_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pol_o = 1'h0;
		energy_o = 1'h1;
		ev_o = 7'h00;
		mode_o = 3'h0;
	end
	// Four cycles is enough to cross the two-flop synchroniser
	task fire(input int b);
		@(posedge clk_i);
		ev_o[b] <= 1'h1;
		repeat (4) @(posedge clk_i);
		ev_o[b] <= 1'h0;
	endtask
endmodule
`default_nettype wire

//--- testbench/phy_status_properties.sv
// Port-level checks of the PHY status block
`default_nettype none
module phy_status_properties
	import phy_irq_pkg::*;
#(
	parameter int ADDR_W         = 8,
	parameter int TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYC
)
(
	// System
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Bus
	input wire logic              cyc_i,
	input wire logic              stb_i,
	input wire logic              we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0]        sel_i,
	input wire logic [31:0]       dat_i,
	input wire logic [31:0]       dat_o,
	input wire logic              ack_o,
	// Line and outputs
	input wire logic              line_energy_present_i,
	input wire logic              scrambler_disable_o,
	input wire logic              line_energy_indication_o,
	input wire logic              irq_o
);
	logic [31:0] quiet_cnt;
	wire logic [5:0] idx = adr_i[7:2];
	wire logic taken = cyc_i && stb_i && !ack_o;
	wire logic rd_take = taken && !we_i;
	wire logic mapped = idx >= IDX_RX_POLARITY && idx <= IDX_SPECIAL;
	wire logic wr_low = taken && we_i && sel_i[0];
	wire logic wr_en0 = wr_low && idx == IDX_EVENT_ENABLE && dat_i[7:1] == 7'h00;
	wire logic wr_special = wr_low && idx == IDX_SPECIAL;
	// Pin-level quiet count; an upper bound on what the block can have seen
	always_ff @(posedge clk_i) begin
		if (rst_i || line_energy_present_i)
			quiet_cnt <= 32'h0;
		else
			quiet_cnt <= quiet_cnt + 32'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_at(logic [5:0] i);
		rd_take && idx == i;
	endsequence
	ack_latency_a: assert property (taken |=> ack_o) else $error("no ack");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	unmapped_zero_a: assert property (rd_take && !mapped |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	polarity_rsvd_a: assert property (rd_at(IDX_RX_POLARITY) |=> (dat_o & ~32'h10) == 32'h0)
		else $error("polarity reserved bits set");
	status_rsvd_a: assert property (rd_at(IDX_EVENT_STATUS) |=> (dat_o & ~32'hfe) == 32'h0)
		else $error("status reserved bits set");
	enable_rsvd_a: assert property (rd_at(IDX_EVENT_ENABLE) |=> (dat_o & ~32'hfe) == 32'h0)
		else $error("enable reserved bits set");
	special_rsvd_a: assert property (rd_at(IDX_SPECIAL) |=> dat_o[11:5] == 7'h00)
		else $error("special reserved bits set");
	mask_off_a: assert property (wr_en0 |-> ##3 !irq_o)
		else $error("irq with all enables clear");
	scr_change_a: assert property ($changed(scrambler_disable_o) |->
		$past(wr_special) || $past(wr_special, 2)) else $error("scrambler moved without write");
	energy_fall_a: assert property ($fell(line_energy_indication_o) |->
		quiet_cnt >= TIMEOUT_CYCLES) else $error("energy cleared early");
	energy_rise_a: assert property (line_energy_present_i [*5] |-> line_energy_indication_o)
		else $error("energy indication not set");
endmodule
bind phy_interrupt_status_control phy_status_properties #(
	.ADDR_W(ADDR_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) props (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.line_energy_present_i(line_energy_present_i), .scrambler_disable_o(scrambler_disable_o),
	.line_energy_indication_o(line_energy_indication_o), .irq_o(irq_o));
`default_nettype wire

//--- testbench/phy_interrupt_status_control_tb_top.sv
// Self-checking bench for the PHY status and interrupt registers
`default_nettype none
module phy_interrupt_status_control_tb_top
	import phy_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        cyc_i = 1'h0;
	logic        stb_i = 1'h0;
	logic        we_i = 1'h0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, rd;
	logic        ack_o, scr_o, eni_o, irq_o, pol, energy;
	logic [7:1]  ev;
	logic [2:0]  mode;
	int          error_cnt = 0;
	int          checks = 0;
	always #5 clk_i = ~clk_i;
	phy_link_partner lp (.clk_i(clk_i), .pol_o(pol), .energy_o(energy), .ev_o(ev), .mode_o(mode));
	phy_interrupt_status_control #(.TIMEOUT_CYCLES(20)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.rx_polarity_reversed_i(pol), .line_energy_present_i(energy),
		.negotiation_done_i(ev[6]), .remote_fault_i(ev[5]), .link_status_i(~ev[4]),
		.partner_ack_i(ev[3]), .parallel_detect_fault_i(ev[2]), .page_received_i(ev[1]),
		.link_mode_i(mode), .scrambler_disable_o(scr_o), .line_energy_indication_o(eni_o),
		.irq_o(irq_o));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		if (ack_o !== 1'h1) begin
			error_cnt++;
			end_sim();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic t_reset();
		rdchk(8'h6c, 32'h0);
		rdchk(8'h74, 32'h0);
		rdchk(8'h78, 32'h0);
		rdchk(8'h7c, 32'h0);
		chk(eni_o, 32'h1);
	endtask
	task automatic t_events();
		wb(1'h1, 8'h70, 32'hfe);
		for (int b = 1; b < 7; b++) begin
			wb(1'h1, 8'h78, 32'hfe ^ (32'h1 << b));
			lp.fire(b);
			repeat (3) @(posedge clk_i);
			chk(irq_o, 32'h0);
			rdchk(8'h74, 32'h1 << b);
			wb(1'h1, 8'h78, 32'hfe);
			repeat (3) @(posedge clk_i);
			chk(irq_o, 32'h1);
			wb(1'h1, 8'h70, 32'h1 << b);
			repeat (3) @(posedge clk_i);
			chk(irq_o, 32'h0);
		end
	endtask
	task automatic t_energy();
		wb(1'h1, 8'h78, 32'h80);
		lp.energy_o <= 1'h0;
		repeat (40) @(posedge clk_i);
		chk(eni_o, 32'h0);
		chk(irq_o, 32'h1);
		rdchk(8'h74, 32'h80);
		wb(1'h1, 8'h78, 32'h0);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 32'h0);
		lp.energy_o <= 1'h1;
		repeat (6) @(posedge clk_i);
		chk(eni_o, 32'h1);
		lp.energy_o <= 1'h0;
		repeat (40) @(posedge clk_i);
		chk(eni_o, 32'h0);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chk(eni_o, 32'h1);
		rdchk(8'h74, 32'h0);
		lp.energy_o <= 1'h1;
		wb(1'h1, 8'h70, 32'hfe);
		wb(1'h1, 8'h74, 32'hffff);
		rdchk(8'h74, 32'h0);
		rdchk(8'h40, 32'h0);
		wb(1'h1, 8'h78, 32'hffff);
		rdchk(8'h78, 32'hfe);
	endtask
	task automatic t_special();
		logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
		lp.pol_o <= 1'h1;
		lp.ev_o[6] <= 1'h1;
		wb(1'h1, 8'h7c, 32'h0001);
		repeat (3) @(posedge clk_i);
		chk(scr_o, 32'h1);
		rdchk(8'h6c, 32'h10);
		foreach (modes[i]) begin
			lp.mode_o <= modes[i];
			repeat (4) @(posedge clk_i);
			rdchk(8'h7c, 32'h1001 | (32'(modes[i]) << 2));
		end
		wb(1'h1, 8'h7c, 32'h0000);
		repeat (3) @(posedge clk_i);
		chk(scr_o, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_events();
		t_energy();
		t_special();
		end_sim();
	end
endmodule
`default_nettype wire
